// file: result_buffer.sv
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module result_buffer #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [1:0]            fill
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
    } buf_state_t;
    buf_state_t st;
    buf_state_t next_st;
    logic push;
    logic pop;
    assign in_ready  = (st.count != (PW + 1)'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data  = st.mem[st.rd_ptr];
    assign fill      = 2'(st.count);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr_ptr] = in_data;
            next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
        end
        next_st.count = st.count + (PW + 1)'(push) - (PW + 1)'(pop);
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// file: sar_conversion_control.sv
// Successive-approximation conversion control with Avalon-MM register access
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sar_conversion_control #(
    parameter int STALE_IDLE_CYCLES = sar_pkg::STALE_IDLE_CYC,
    parameter int BUF_DEPTH         = 2
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        conversion_start_n,
    input  wire logic        conversion_reset,
    input  wire logic        power_down_input,
    input  wire logic        output_coding_select,
    input  wire logic        comparator_out,
    input  wire logic        input_over_range,
    input  wire logic        input_under_range,
    output logic             busy,
    output logic             array_common_switch,
    output logic             dummy_common_switch,
    output logic [15:0]      dac_switches,
    output logic             analog_bias_enable,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    localparam int IDLE_W = $clog2(STALE_IDLE_CYCLES + 1);

    // ==========================================
    // State record
    typedef struct packed {
        sar_pkg::phase_t  phase;
        logic [1:0]       mode;
        logic             start_q;
        logic [15:0]      count;
        logic [7:0]       step;
        logic [15:0]      trial;
        logic [15:0]      mask;
        logic             over;
        logic             under;
        logic             stale;
        logic             last_stale;
        logic [IDLE_W-1:0] idle;
        logic             busy;
        logic             sw_closed;
        logic             bias;
        logic [15:0]      dac;
        logic [31:0]      rdata;
        logic             waitreq;
    } ctrl_state_t;

    ctrl_state_t st;
    ctrl_state_t next_st;

    // ==========================================
    // Result buffer
    logic [17:0] buf_in;
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic [17:0] buf_out;
    logic        buf_out_valid;
    logic        buf_pop;
    logic [1:0]  buf_fill;
    logic [15:0] code;
    logic [15:0] binary;
    logic        fall;
    logic [15:0] acq_len;
    logic        bus_access;

    result_buffer #(
        .WIDTH (18),
        .DEPTH (BUF_DEPTH)
    ) u_result_buffer (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_data   (buf_in),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out),
        .out_valid (buf_out_valid),
        .out_ready (buf_pop),
        .fill      (buf_fill)
    );

    // ==========================================
    // Output code forming
    always_comb begin
        if (st.over) begin
            binary = sar_pkg::CODE_MAX;
        end else if (st.under) begin
            binary = sar_pkg::CODE_MIN;
        end else begin
            binary = st.trial;
        end
        // Twos complement is straight binary with the top bit turned over
        if (output_coding_select) begin
            code = binary;
        end else begin
            code = {~binary[15], binary[14:0]};
        end
    end

    // Result is pushed only in the finishing phase, so it is always this sample's
    assign buf_in       = {st.stale, 1'b1, code};
    assign buf_in_valid = (st.phase == sar_pkg::PH_FINISH);

    // Bus access completes at the edge where waitrequest is low
    assign bus_access = (avs_read || avs_write) && !st.waitreq;
    assign buf_pop    = bus_access && avs_read && (avs_address == sar_pkg::RESULT_ADDR);

    assign fall = st.start_q && !conversion_start_n;

    always_comb begin
        case (st.mode)
            2'(sar_pkg::MODE_WARP):  acq_len = 16'(sar_pkg::WARP_ACQ_CYC);
            2'(sar_pkg::MODE_BURST): acq_len = 16'(sar_pkg::BURST_ACQ_CYC);
            default:                 acq_len = 16'(sar_pkg::NORMAL_ACQ_CYC);
        endcase
    end

    // ==========================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.start_q = conversion_start_n;
        if (st.idle != IDLE_W'(STALE_IDLE_CYCLES)) begin
            next_st.idle = st.idle + 1'b1;
        end

        case (st.phase)
            sar_pkg::PH_ACQUIRE: begin
                next_st.sw_closed = 1'b1;
                next_st.bias = !power_down_input;
                if (st.count >= acq_len) begin
                    next_st.phase = sar_pkg::PH_READY;
                    next_st.count = '0;
                end else begin
                    next_st.count = st.count + 1'b1;
                end
            end
            sar_pkg::PH_READY: begin
                // Analog section idles unpowered in burst mode until a start comes
                next_st.bias = !power_down_input && (st.mode != 2'(sar_pkg::MODE_BURST));
                if (!power_down_input) begin
                    if (fall || (st.mode == 2'(sar_pkg::MODE_BURST) && !conversion_start_n
                                 && st.count == '0)) begin
                        next_st.phase = sar_pkg::PH_CONVERT;
                        next_st.sw_closed = 1'b0;
                        next_st.bias = 1'b1;
                        next_st.busy = 1'b1;
                        next_st.trial = '0;
                        next_st.mask = sar_pkg::MSB_MASK;
                        next_st.dac = sar_pkg::MSB_MASK;
                        next_st.step = '0;
                        next_st.over = input_over_range;
                        next_st.under = input_under_range;
                        next_st.stale = (st.mode == 2'(sar_pkg::MODE_WARP))
                                        && (st.idle == IDLE_W'(STALE_IDLE_CYCLES));
                        next_st.idle = '0;
                    end
                end
                // The burst immediate start only looks at the first waiting cycle
                next_st.count = 16'h0001;
            end
            sar_pkg::PH_CONVERT: begin
                // Start edges here are not looked at
                if (st.step == sar_pkg::BIT_STEP_COUNT) begin
                    next_st.step = '0;
                    // Keep the trial bit when the held input is at or above the trial level
                    if (comparator_out) begin
                        next_st.trial = st.trial | st.mask;
                    end
                    next_st.mask = st.mask >> 1;
                    if (st.mask[0]) begin
                        next_st.phase = sar_pkg::PH_FINISH;
                        next_st.dac = '0;
                    end else begin
                        next_st.dac = (comparator_out ? (st.trial | st.mask) : st.trial)
                                      | (st.mask >> 1);
                    end
                end else begin
                    next_st.step = st.step + 1'b1;
                end
            end
            sar_pkg::PH_FINISH: begin
                // A full buffer stalls here with busy still high
                if (buf_in_ready) begin
                    next_st.busy = 1'b0;
                    next_st.last_stale = st.stale;
                    next_st.phase = sar_pkg::PH_ACQUIRE;
                    next_st.count = '0;
                    next_st.sw_closed = 1'b1;
                end
            end
            default: begin
                next_st.phase = sar_pkg::PH_ACQUIRE;
                next_st.count = '0;
            end
        endcase

        if (conversion_reset) begin
            next_st.phase = sar_pkg::PH_ACQUIRE;
            next_st.count = '0;
            next_st.busy = 1'b0;
            next_st.sw_closed = 1'b1;
            next_st.dac = '0;
            next_st.trial = '0;
            next_st.mask = '0;
        end

        // ==========================================
        // Avalon-MM slave: one wait cycle, then the access completes
        next_st.waitreq = 1'b1;
        if ((avs_read || avs_write) && st.waitreq) begin
            next_st.waitreq = 1'b0;
            case (avs_address)
                sar_pkg::CONTROL_ADDR: next_st.rdata = {30'h0, st.mode};
                sar_pkg::STATUS_ADDR: begin
                    next_st.rdata = 32'h0;
                    next_st.rdata[sar_pkg::STAT_BUSY_BIT] = st.busy;
                    next_st.rdata[sar_pkg::STAT_AVAIL_BIT] = buf_out_valid;
                    next_st.rdata[sar_pkg::STAT_STALE_BIT] = st.last_stale;
                    next_st.rdata[sar_pkg::STAT_PD_BIT] = power_down_input;
                    next_st.rdata[sar_pkg::STAT_FILL_LSB +: 2] = buf_fill;
                end
                sar_pkg::RESULT_ADDR: next_st.rdata = {14'h0, buf_out_valid ? buf_out : 18'h0};
                default: next_st.rdata = 32'h0;
            endcase
        end
        if (bus_access && avs_write && avs_address == sar_pkg::CONTROL_ADDR
            && avs_byteenable[0]) begin
            next_st.mode = avs_writedata[sar_pkg::CTRL_MODE_MSB:sar_pkg::CTRL_MODE_LSB];
        end
    end

    // ==========================================
    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.phase <= sar_pkg::PH_ACQUIRE;
            st.mode <= sar_pkg::CTRL_MODE_RESET;
            st.start_q <= 1'b1;
            st.sw_closed <= 1'b1;
            st.waitreq <= 1'b1;
            // Power-up counts as a long idle
            st.idle <= IDLE_W'(STALE_IDLE_CYCLES);
        end else begin
            st <= next_st;
        end
    end

    assign busy                = st.busy;
    assign array_common_switch = st.sw_closed;
    assign dummy_common_switch = st.sw_closed;
    assign dac_switches        = st.dac;
    assign analog_bias_enable  = st.bias;
    assign avs_readdata        = st.rdata;
    assign avs_waitrequest     = st.waitreq;
endmodule
`default_nettype wire

// file: sar_conversion_control_props.sv
// Concurrent checks on the conversion control top-level ports
`timescale 1ns/10ps
`default_nettype none
module sar_checks (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        conversion_start_n,
    input wire logic        conversion_reset,
    input wire logic        power_down_input,
    input wire logic        busy,
    input wire logic        array_common_switch,
    input wire logic        dummy_common_switch,
    input wire logic [15:0] dac_switches,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ==========================================
    // Conversion sequence
    sequence conv_begin;
        $rose(busy);
    endsequence
    sequence second_trial;
        conv_begin ##10 1'b1;
    endsequence
    a_start_cause: assert property (conv_begin |-> !$past(conversion_start_n))
        else $error("busy rose without start low");
    a_switch_open: assert property (busy |-> !array_common_switch && !dummy_common_switch)
        else $error("switch closed while busy");
    a_msb_first: assert property (conv_begin |-> dac_switches == 16'h8000)
        else $error("first trial not msb");
    a_next_trial: assert property (second_trial |-> dac_switches[14:0] == 15'h4000)
        else $error("second trial wrong");
    a_busy_len: assert property ($fell(busy) && !$past(conversion_reset) |-> $past(busy, 150))
        else $error("busy too short");
    a_busy_bound: assert property (conv_begin |-> ##[150:175] !busy)
        else $error("busy never dropped");
    // A nonzero trial word means bit decisions are still running, so busy must hold
    a_no_restart: assert property (busy && dac_switches != 16'h0 && $fell(conversion_start_n)
        && !conversion_reset |=> busy)
        else $error("start in conversion disturbed busy");
    a_reset_abort: assert property (conversion_reset |=> !busy && array_common_switch)
        else $error("soft reset did not abort");
    a_pd_refuse: assert property (conv_begin |-> !$past(power_down_input))
        else $error("start accepted in power down");
    // One wait state, then the slave idles again
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing");
endmodule
bind sar_conversion_control sar_checks u_sar_checks (.clk_sys(clk_sys), .reset_n(reset_n),
    .conversion_start_n(conversion_start_n), .conversion_reset(conversion_reset),
    .power_down_input(power_down_input), .busy(busy), .array_common_switch(array_common_switch),
    .dummy_common_switch(dummy_common_switch), .dac_switches(dac_switches), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// file: sar_conversion_control_tb.sv
// Self-checking bench for the conversion control
`timescale 1ns/10ps
`default_nettype none
module sar_conversion_control_tb;
    logic clk_sys = 0, reset_n = 0, conversion_start_n = 1, conversion_reset = 0, power_down_input = 0;
    logic output_coding_select = 1, comparator_out, input_over_range = 0, input_under_range = 0;
    logic busy, array_common_switch, dummy_common_switch, analog_bias_enable, avs_read = 0, avs_write = 0;
    logic avs_waitrequest;
    logic [15:0] dac_switches, input_level = 16'h0000;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic [31:0] exp_q[$];
    logic [1:0]  mode;
    int error_cnt = 0, total_checks = 0;
    logic [31:0] seed = 32'd18;
    always #2 clk_sys = ~clk_sys;
    sar_conversion_control #(.STALE_IDLE_CYCLES(50)) u_sar_conversion_control (.clk_sys(clk_sys),
        .reset_n(reset_n), .conversion_start_n(conversion_start_n), .conversion_reset(conversion_reset),
        .power_down_input(power_down_input), .output_coding_select(output_coding_select),
        .comparator_out(comparator_out), .input_over_range(input_over_range),
        .input_under_range(input_under_range), .busy(busy), .array_common_switch(array_common_switch),
        .dummy_common_switch(dummy_common_switch), .dac_switches(dac_switches),
        .analog_bias_enable(analog_bias_enable), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    sar_front_end_model u_sar_front_end_model (.input_level(input_level),
        .array_common_switch(array_common_switch), .dac_switches(dac_switches), .comparator_out(comparator_out));
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    // ==========================================
    // Avalon-MM master: called just after a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge clk_sys);
        // Only the watchdog ends this wait
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk_sys);
    endtask
    task automatic convert(input logic [15:0] lvl, input logic ovr, input logic und);
        int n = 0;
        logic [15:0] code;
        input_level <= lvl;
        input_over_range <= ovr;
        input_under_range <= und;
        // Longest acquisition (burst) is 214 cycles
        repeat (230) @(posedge clk_sys);
        chk("ready bias", mode != 2'h2, analog_bias_enable);
        conversion_start_n <= 0;
        while (busy !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        chk("busy rise", 1, busy);
        input_level <= ~lvl;
        conversion_start_n <= 1;
        repeat (3) @(posedge clk_sys);
        conversion_start_n <= 0;
        @(posedge clk_sys);
        conversion_start_n <= 1;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk_sys);
            n++;
        end
        chk("busy fall", 0, busy);
        code = ovr ? 16'hffff : und ? 16'h0000 : lvl;
        if (!output_coding_select) code ^= 16'h8000;
        exp_q.push_back({14'h0, mode == 2'h1, 1'b1, code});
    endtask
    task automatic pop2();
        repeat (2) begin
            bus(0, 4'h8, 0, rd);
            chk("result", exp_q.pop_front(), rd);
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        bus(0, 4'h0, 0, rd);
        chk("control reset", 0, rd);
        bus(0, 4'hc, 0, rd);
        chk("unmapped", 0, rd);
        for (int i = 0; i < 6; i++) begin
            mode = 2'(i % 3);
            output_coding_select <= i[0];
            bus(1, 4'h0, {30'h0, mode}, rd);
            bus(0, 4'h0, 0, rd);
            chk("mode", {30'h0, mode}, rd);
            convert(16'(xorshift()), 0, 0);
            case (i)
                0, 1: convert(16'h8000, 0, 0);
                2, 5: convert(16'h7fff, 0, 0);
                3: convert(16'h1234, 1, 0);
                default: convert(16'h4321, 0, 1);
            endcase
            pop2();
        end
        // Burst: start held low through acquisition converts at once
        conversion_start_n <= 0;
        repeat (230) @(posedge clk_sys);
        chk("burst held start", 1, busy);
        conversion_start_n <= 1;
        repeat (200) @(posedge clk_sys);
        bus(0, 4'h8, 0, rd);
        chk("burst result", {14'h0, 2'b01, input_level}, rd);
        // Abort in mid-conversion
        repeat (230) @(posedge clk_sys);
        conversion_start_n <= 0;
        repeat (40) @(posedge clk_sys);
        conversion_start_n <= 1;
        conversion_reset <= 1;
        @(posedge clk_sys);
        conversion_reset <= 0;
        @(posedge clk_sys);
        chk("abort busy", 0, busy);
        bus(0, 4'h4, 0, rd);
        chk("no result", 0, rd[1]);
        power_down_input <= 1;
        repeat (230) @(posedge clk_sys);
        conversion_start_n <= 0;
        repeat (20) @(posedge clk_sys);
        chk("pd busy", 0, busy);
        chk("pd bias", 0, analog_bias_enable);
        bus(0, 4'h4, 0, rd);
        chk("pd status", 32'h8, rd & 32'hf);
        close_out();
    end
endmodule
`default_nettype wire

// file: sar_front_end_model.sv
// Behavioural sample-and-hold and comparator facing the conversion control
`timescale 1ns/10ps
`default_nettype none
module sar_front_end_model (
    input wire logic [15:0] input_level,
    input wire logic        array_common_switch,
    input wire logic [15:0] dac_switches,
    output logic            comparator_out
);
    logic [15:0] held;
    initial held = 16'h0000;
    // Capture only when the array leaves the input; later input changes must not leak in
    always @(negedge array_common_switch) held = input_level;
    // While acquiring, the comparator output carries nothing useful, so it wanders
    assign comparator_out = array_common_switch ? dac_switches[0] ^ held[0] : (held >= dac_switches);
endmodule
`default_nettype wire

// file: sar_pkg.sv
// Constants, types and timing for the successive-approximation conversion control
// Behaviour
// - Start falling ends acquisition, opens both common switches, holds the sample.
// - Sixteen binary-weighted trial steps, most significant bit first, down to one LSB.
// - After the last decision form the output code, then drop busy.
// - Each result belongs to the sample just taken; no pipeline delay.
// - Three selectable modes; the fastest allows up to 1 MSPS.
// - Normal mode runs up to 800 kSPS, accurate at any interval.
// - Burst mode cuts analog power while idle between conversions.
// - Coding select picks straight binary or twos complement output.
// - Midscale reads 8000 or 0000; twos complement inverts the top bit.
// - Overrange saturates to FFFF binary or 7FFF twos complement.
// - Underrange saturates to 0000 binary or 8000 twos complement.
// - Conversion reset high reinitialises and aborts any conversion.
// - Power-down finishes the current conversion, then refuses new starts.
// - Burst mode: start already low at acquisition end converts immediately.
package sar_pkg;
    // ==========================================
    // Register map
    localparam logic [3:0] CONTROL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR  = 4'h4;
    localparam logic [3:0] RESULT_ADDR  = 4'h8;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 1;
    localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_AVAIL_BIT = 1;
    localparam int STAT_STALE_BIT = 2;
    localparam int STAT_PD_BIT    = 3;
    localparam int STAT_FILL_LSB  = 4;
    localparam int RES_VALID_BIT  = 16;
    localparam int RES_STALE_BIT  = 17;
    // ==========================================
    // Converter geometry and codes
    localparam int SAR_BITS = 16;
    localparam logic [15:0] MSB_MASK  = 16'h8000;
    localparam logic [15:0] CODE_MAX  = 16'hffff;
    localparam logic [15:0] CODE_MIN  = 16'h0000;
    // ==========================================
    // Timing at the system clock rate
    localparam int CLK_MHZ       = 250;
    localparam int BIT_STEP_NS   = 40;
    localparam int WARP_PERIOD_NS   = 1000;
    localparam int NORMAL_PERIOD_NS = 1250;
    localparam int BURST_PERIOD_NS  = 1500;
    localparam int STALE_IDLE_NS    = 1000000;
    localparam int CONV_OVERHEAD_CYC = 2;
    localparam int BIT_STEP_CYC = (BIT_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CYC = SAR_BITS * BIT_STEP_CYC + CONV_OVERHEAD_CYC;
    localparam int WARP_ACQ_CYC   = (WARP_PERIOD_NS * CLK_MHZ + 999) / 1000 - CONV_CYC;
    localparam int NORMAL_ACQ_CYC = (NORMAL_PERIOD_NS * CLK_MHZ + 999) / 1000 - CONV_CYC;
    localparam int BURST_ACQ_CYC  = (BURST_PERIOD_NS * CLK_MHZ + 999) / 1000 - CONV_CYC;
    localparam int STALE_IDLE_CYC = STALE_IDLE_NS / 1000 * CLK_MHZ;
    localparam logic [7:0] BIT_STEP_COUNT = 8'(BIT_STEP_CYC - 1);
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_WARP,
        MODE_BURST
    } mode_t;
    typedef enum logic [2:0] {
        PH_ACQUIRE,
        PH_READY,
        PH_CONVERT,
        PH_FINISH
    } phase_t;
endpackage
